// File: src/fpa_pkg.sv
// Purpose: Shared constants and types for the FM acquisition help and auto-mute block
// Assumes: 50 MHz system clock used as the frequency reference for all timing
// Notes: Carrier table in Hz, times in their own units, cycle counts derived
package fpa_pkg;

  // Clock and timing
  localparam longint unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYCLE_US = 256;
  localparam int unsigned COUNT_US = 64;
  localparam int unsigned PULSE_US = 10;
  localparam int unsigned MUTE_MS = 40;
  localparam int unsigned IDENT_NORM_MS = 2000;
  localparam int unsigned IDENT_FAST_MS = 500;
  localparam int unsigned ACQ_CYCLE_CYC = int'(CLK_HZ * CYCLE_US / 1_000_000);
  localparam int unsigned COUNT_CYC = int'(CLK_HZ * COUNT_US / 1_000_000);
  localparam int unsigned PULSE_CYC = int'(CLK_HZ * PULSE_US / 1_000_000);
  localparam int unsigned MUTE_CYC = int'(CLK_HZ * MUTE_MS / 1000);
  localparam int unsigned IDENT_NORM_CYC = int'(CLK_HZ * IDENT_NORM_MS / 1000);
  localparam int unsigned IDENT_FAST_CYC = int'(CLK_HZ * IDENT_FAST_MS / 1000);

  // Lock windows in Hz
  localparam longint unsigned CARRIER_WIN_HZ = 225_000;
  localparam longint unsigned PILOT_WIN_HZ = 150;

  // Sound standards
  localparam int unsigned NUM_STD = 6;
  localparam logic [2:0] STD_M = 3'h0;
  localparam logic [2:0] STD_BG = 3'h1;
  localparam logic [2:0] STD_I = 3'h2;
  localparam logic [2:0] STD_DK1 = 3'h3;
  localparam logic [2:0] STD_DK2 = 3'h4;
  localparam logic [2:0] STD_DK3 = 3'h5;

  // Nominal carrier frequencies per standard, zero where no carrier exists
  localparam longint unsigned SC1_HZ [NUM_STD] = '{4_500_000, 5_500_000, 6_000_000,
                                                  6_500_000, 6_500_000, 6_500_000};
  localparam longint unsigned SC2_HZ [NUM_STD] = '{4_720_000, 5_740_000, 0,
                                                  6_260_000, 6_740_000, 5_740_000};

  // PLL indices
  localparam logic [1:0] PLL_SC1 = 2'h0;
  localparam logic [1:0] PLL_SC2 = 2'h1;
  localparam logic [1:0] PLL_PILOT = 2'h2;

  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE0 = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE1 = 8'h0c;
  localparam logic [7:0] ADDR_SAMPLE2 = 8'h10;

  // Control fields and reset values
  localparam int unsigned CTRL_MUTE_EN_BIT = 0;
  localparam int unsigned CTRL_FAST_BIT = 1;
  localparam int unsigned CTRL_STD_LSB = 2;
  localparam logic CTRL_MUTE_EN_RST = 1'b1;
  localparam logic CTRL_FAST_RST = 1'b0;
  localparam logic [2:0] CTRL_STD_RST = STD_BG;

  // Status fields
  localparam int unsigned STAT_MUTE1_BIT = 0;
  localparam int unsigned STAT_MUTE2_BIT = 1;
  localparam int unsigned STAT_IDENT_BIT = 2;
  localparam int unsigned STAT_WIN_LSB = 3;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fpa_req_type;

  // One table entry: counter preset and expected remaining range
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] lo;
    logic [15:0] hi;
    logic valid;
  } fpa_entry_type;

endpackage : fpa_pkg

// File: src/fpa_table.sv
// Purpose: Registered lookup of counter preset and expected range per standard and PLL
// Assumes: Oscillator ticks arrive pre-scaled so a count window gives usable resolution
// Notes: Read data appear one clock after the address
`timescale 1ns/1ps
module fpa_table #(
  parameter longint unsigned PILOT_HZ = 54_688 // Nominal pilot tick rate
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [2:0] std_sel, // Selected sound standard
  input wire logic [1:0] pll_idx, // PLL being measured
  output fpa_pkg::fpa_entry_type entry // Registered table entry
);
  import fpa_pkg::*;

  fpa_entry_type next_entry;

  // Build one entry from a nominal frequency and a window half-width
  function automatic fpa_entry_type make_entry(input longint unsigned f_hz,
                                               input longint unsigned w_hz);
    longint unsigned nom;
    longint unsigned win;
    fpa_entry_type e;
    nom = f_hz * COUNT_US / 1_000_000;
    win = w_hz * COUNT_US / 1_000_000;
    e.start = 16'(2 * nom);
    e.lo = 16'(nom - win);
    e.hi = 16'(nom + win);
    e.valid = (f_hz != 0);
    return e;
  endfunction : make_entry

  // Table selection by standard and PLL
  always_comb begin
    next_entry = '0;
    if (int'(std_sel) < NUM_STD) begin
      case (pll_idx)
        PLL_SC1: next_entry = make_entry(SC1_HZ[std_sel], CARRIER_WIN_HZ);
        PLL_SC2: next_entry = make_entry(SC2_HZ[std_sel], CARRIER_WIN_HZ);
        PLL_PILOT: next_entry = make_entry(PILOT_HZ, PILOT_WIN_HZ);
        default: next_entry = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      entry <= '0;
    end else begin
      entry <= next_entry;
    end
  end

endmodule : fpa_table

// File: src/fpa_acq_mute.sv
// Purpose: Acquisition help for three narrow-band PLLs plus auto-mute and ident timing
// Assumes: vco_tick inputs are one-cycle strobes synchronous to sys_clk
// Notes: Registers on a plain port, read data one cycle after the read strobe
// Notes on behaviour
// - One oscillator at a time feeds counter
// - Counter preset per PLL and standard
// - Sample remainder after fixed window, compare
// - Below range pull down, above pull up
// - Inside range, no correction current
// - Endless round robin over three PLLs
// - Reference-timed, full cycle 256 us
// - Carrier window plus minus 225 kHz
// - Pilot window plus minus 150 Hz
// - Carrier out of window gives acquisition pulse
// - Auto-mute acts only when enabled
// - Mute at once on first pulse
// - Release after 40 ms without pulses
// - First carrier missing mutes second channel
// - Ident settles 2 s normal, 0.5 s fast
// - Fast to normal: ident invalid one period
// - Reset mutes both, auto-mute enabled
`timescale 1ns/1ps
module fpa_acq_mute #(
  parameter int unsigned CYCLE_CYC = fpa_pkg::ACQ_CYCLE_CYC, // Full acquisition cycle
  parameter int unsigned MUTE_HOLD_CYC = fpa_pkg::MUTE_CYC, // Mute release delay
  parameter int unsigned IDENT_NORM_CYC = fpa_pkg::IDENT_NORM_CYC, // Normal settle time
  parameter int unsigned IDENT_FAST_CYC = fpa_pkg::IDENT_FAST_CYC, // Fast settle time
  parameter longint unsigned PILOT_HZ = 54_688 // Nominal pilot tick rate
) (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire fpa_pkg::fpa_req_type reg_req, // Register port request
  output logic [31:0] reg_rdata, // Read data, cycle after read strobe
  input wire logic [2:0] vco_tick, // Pre-scaled oscillator strobes
  output logic [2:0] vco_sel, // One-hot oscillator to counter
  output logic [2:0] corr_up, // Positive loop filter current
  output logic [2:0] corr_dn, // Negative loop filter current
  output logic acq_pulse, // Carrier acquisition pulse
  output logic mute_main, // Mute first audio channel
  output logic mute_second, // Mute second audio channel
  output logic ident_valid // Identification bits valid
);
  import fpa_pkg::*;

  localparam int unsigned SLOT_CYC = CYCLE_CYC / 3;
  localparam int unsigned LAST_SLOT_CYC = CYCLE_CYC - 2 * SLOT_CYC;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_PRESET = 3'b001,
    ST_COUNT = 3'b011,
    ST_CORR = 3'b010,
    ST_WAIT = 3'b110
  } fpa_state_type;

  // One-hot decode of a PLL index
  function automatic logic [2:0] onehot(input logic [1:0] idx);
    logic [2:0] v;
    v = 3'h0;
    if (idx <= PLL_PILOT) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction : onehot

  // Control register
  logic mute_en;
  logic ident_fast;
  logic [2:0] std_sel;
  logic next_mute_en;
  logic next_ident_fast;
  logic [2:0] next_std_sel;
  logic [31:0] next_rdata;

  // Sequencer state
  fpa_state_type state;
  fpa_state_type next_state;
  logic [1:0] pll_idx;
  logic [1:0] next_pll_idx;
  logic [23:0] slot_cnt;
  logic [23:0] next_slot_cnt;
  logic [23:0] ph_cnt;
  logic [23:0] next_ph_cnt;
  logic [15:0] down_cnt;
  logic [15:0] next_down_cnt;
  logic [1:0] corr_dir;
  logic [1:0] next_corr_dir;
  logic [2:0] in_win;
  logic [2:0] next_in_win;
  logic [15:0] sample [3];
  logic [15:0] next_sample [3];
  logic [2:0] next_vco_sel;
  logic [2:0] next_corr_up;
  logic [2:0] next_corr_dn;
  logic next_acq_pulse;
  fpa_entry_type entry;
  logic slot_end;

  // Mute state
  logic mute1;
  logic mute2;
  logic next_mute1;
  logic next_mute2;
  logic [31:0] mute1_cnt;
  logic [31:0] mute2_cnt;
  logic [31:0] next_mute1_cnt;
  logic [31:0] next_mute2_cnt;

  // Ident settle state
  logic fast_q;
  logic next_fast_q;
  logic [31:0] ident_cnt;
  logic [31:0] next_ident_cnt;
  logic next_ident_valid;

  // Table lookup for current standard and PLL
  fpa_table #(
    .PILOT_HZ(PILOT_HZ)
  ) u_table (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .std_sel(std_sel),
    .pll_idx(pll_idx),
    .entry(entry)
  );

  // Register port: writes to control, reads of control, status and samples
  always_comb begin
    next_mute_en = mute_en;
    next_ident_fast = ident_fast;
    next_std_sel = std_sel;
    next_rdata = 32'h0;
    if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
      next_mute_en = reg_req.wdata[CTRL_MUTE_EN_BIT];
      next_ident_fast = reg_req.wdata[CTRL_FAST_BIT];
      next_std_sel = reg_req.wdata[CTRL_STD_LSB +: 3];
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL: begin
          next_rdata[CTRL_MUTE_EN_BIT] = mute_en;
          next_rdata[CTRL_FAST_BIT] = ident_fast;
          next_rdata[CTRL_STD_LSB +: 3] = std_sel;
        end
        ADDR_STATUS: begin
          next_rdata[STAT_MUTE1_BIT] = mute_main;
          next_rdata[STAT_MUTE2_BIT] = mute_second;
          next_rdata[STAT_IDENT_BIT] = ident_valid;
          next_rdata[STAT_WIN_LSB +: 3] = in_win;
        end
        ADDR_SAMPLE0: next_rdata[15:0] = sample[0];
        ADDR_SAMPLE1: next_rdata[15:0] = sample[1];
        ADDR_SAMPLE2: next_rdata[15:0] = sample[2];
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mute_en <= CTRL_MUTE_EN_RST;
      ident_fast <= CTRL_FAST_RST;
      std_sel <= CTRL_STD_RST;
      reg_rdata <= 32'h0;
    end else begin
      mute_en <= next_mute_en;
      ident_fast <= next_ident_fast;
      std_sel <= next_std_sel;
      reg_rdata <= next_rdata;
    end
  end

  // Slot boundary, the last slot takes the remainder of the cycle
  assign slot_end = (pll_idx == PLL_PILOT) ? (slot_cnt == 24'(LAST_SLOT_CYC - 1))
                                           : (slot_cnt == 24'(SLOT_CYC - 1));

  // Measurement sequencer for the selected PLL
  always_comb begin
    logic [15:0] rem;
    rem = down_cnt;
    next_state = state;
    next_pll_idx = pll_idx;
    next_slot_cnt = slot_cnt + 24'h1;
    next_ph_cnt = ph_cnt + 24'h1;
    next_down_cnt = down_cnt;
    next_corr_dir = corr_dir;
    next_in_win = in_win;
    next_sample = sample;
    next_corr_up = 3'h0;
    next_corr_dn = 3'h0;
    next_acq_pulse = 1'b0;
    case (state)
      ST_LOAD: begin
        next_state = ST_PRESET; // Table output follows the new index
        next_ph_cnt = 24'h0;
      end
      ST_PRESET: begin
        next_down_cnt = entry.start;
        next_state = ST_COUNT;
        next_ph_cnt = 24'h0;
      end
      ST_COUNT: begin
        if (vco_tick[pll_idx] && down_cnt != 16'h0) begin
          rem = down_cnt - 16'h1;
        end
        next_down_cnt = rem;
        if (ph_cnt == 24'(COUNT_CYC - 1)) begin
          next_sample[pll_idx] = rem;
          next_ph_cnt = 24'h0;
          next_state = ST_CORR;
          next_in_win[pll_idx] = 1'b0;
          if (!entry.valid) begin
            next_corr_dir = 2'b00;
          end else if (rem < entry.lo) begin
            next_corr_dir = 2'b10;
          end else if (rem > entry.hi) begin
            next_corr_dir = 2'b01;
          end else begin
            next_corr_dir = 2'b00;
            next_in_win[pll_idx] = 1'b1;
          end
          if (pll_idx != PLL_PILOT && entry.valid &&
              (rem < entry.lo || rem > entry.hi)) begin
            next_acq_pulse = 1'b1;
          end
        end
      end
      ST_CORR: begin
        next_corr_up = corr_dir[0] ? onehot(pll_idx) : 3'h0;
        next_corr_dn = corr_dir[1] ? onehot(pll_idx) : 3'h0;
        if (ph_cnt == 24'(PULSE_CYC - 1)) begin
          next_corr_up = 3'h0;
          next_corr_dn = 3'h0;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_ph_cnt = 24'h0;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
    if (slot_end) begin
      next_pll_idx = (pll_idx == PLL_PILOT) ? PLL_SC1 : pll_idx + 2'h1;
      next_slot_cnt = 24'h0;
      next_state = ST_LOAD;
      next_corr_up = 3'h0;
      next_corr_dn = 3'h0;
    end
  end

  assign next_vco_sel = onehot(next_pll_idx);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_LOAD;
      pll_idx <= PLL_SC1;
      slot_cnt <= 24'h0;
      ph_cnt <= 24'h0;
      down_cnt <= 16'h0;
      corr_dir <= 2'b00;
      in_win <= 3'h0;
      sample <= '{default: 16'h0};
      vco_sel <= 3'h1;
      corr_up <= 3'h0;
      corr_dn <= 3'h0;
      acq_pulse <= 1'b0;
    end else begin
      state <= next_state;
      pll_idx <= next_pll_idx;
      slot_cnt <= next_slot_cnt;
      ph_cnt <= next_ph_cnt;
      down_cnt <= next_down_cnt;
      corr_dir <= next_corr_dir;
      in_win <= next_in_win;
      sample <= next_sample;
      vco_sel <= next_vco_sel;
      corr_up <= next_corr_up;
      corr_dn <= next_corr_dn;
      acq_pulse <= next_acq_pulse;
    end
  end

  // Auto-mute: set at once on a pulse, hold timer restarted by each pulse
  always_comb begin
    next_mute1 = mute1;
    next_mute2 = mute2;
    next_mute1_cnt = mute1_cnt;
    next_mute2_cnt = mute2_cnt;
    if (mute1_cnt != 32'h0) begin
      next_mute1_cnt = mute1_cnt - 32'h1;
    end else begin
      next_mute1 = 1'b0;
    end
    if (mute2_cnt != 32'h0) begin
      next_mute2_cnt = mute2_cnt - 32'h1;
    end else begin
      next_mute2 = 1'b0;
    end
    if (acq_pulse && mute_en) begin
      if (pll_idx == PLL_SC1) begin
        next_mute1 = 1'b1;
        next_mute1_cnt = MUTE_HOLD_CYC - 1;
      end
      if (pll_idx == PLL_SC2) begin
        next_mute2 = 1'b1;
        next_mute2_cnt = MUTE_HOLD_CYC - 1;
      end
    end
    if (!mute_en) begin
      next_mute1 = 1'b0;
      next_mute2 = 1'b0;
      next_mute1_cnt = 32'h0;
      next_mute2_cnt = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mute1 <= 1'b1;
      mute2 <= 1'b1;
      mute1_cnt <= MUTE_HOLD_CYC - 1;
      mute2_cnt <= MUTE_HOLD_CYC - 1;
    end else begin
      mute1 <= next_mute1;
      mute2 <= next_mute2;
      mute1_cnt <= next_mute1_cnt;
      mute2_cnt <= next_mute2_cnt;
    end
  end

  assign mute_main = mute1;
  assign mute_second = mute2 | mute1;

  // Ident settle window after each response mode change
  always_comb begin
    next_fast_q = ident_fast;
    next_ident_cnt = ident_cnt;
    if (ident_cnt != 32'h0) begin
      next_ident_cnt = ident_cnt - 32'h1;
    end
    if (ident_fast && !fast_q) begin
      next_ident_cnt = IDENT_FAST_CYC - 1;
    end else if (!ident_fast && fast_q) begin
      next_ident_cnt = IDENT_NORM_CYC - 1;
    end
    next_ident_valid = (next_ident_cnt == 32'h0);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_q <= CTRL_FAST_RST;
      ident_cnt <= IDENT_NORM_CYC - 1;
      ident_valid <= 1'b0;
    end else begin
      fast_q <= next_fast_q;
      ident_cnt <= next_ident_cnt;
      ident_valid <= next_ident_valid;
    end
  end

endmodule : fpa_acq_mute

// File: test/fpa_monitor.sv
// Purpose: Port checker for the acquisition help and auto-mute block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Mute enable and fast bit are shadowed from register writes
`timescale 1ns/1ps
module fpa_monitor
  import fpa_pkg::*;
#(
  parameter int unsigned MUTE_HOLD_CYC = 14000 // Mute release delay
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire fpa_pkg::fpa_req_type reg_req, // Register request
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [2:0] vco_tick, // Oscillator strobes
  input wire logic [2:0] vco_sel, // Counter select
  input wire logic [2:0] corr_up, // Up current
  input wire logic [2:0] corr_dn, // Down current
  input wire logic acq_pulse, // Acquisition pulse
  input wire logic mute_main, // Mute channel 1
  input wire logic mute_second, // Mute channel 2
  input wire logic ident_valid // Ident bits valid
);
  localparam int unsigned PW = PULSE_CYC - 1;
  logic en;
  logic fast;
  logic [2:0] corr;
  int unsigned run;
  int unsigned quiet;
  assign corr = corr_up | corr_dn;
  // Shadow control bits, pulse length and quiet time
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en <= CTRL_MUTE_EN_RST;
      fast <= CTRL_FAST_RST;
      run <= 0;
      quiet <= 0;
    end else begin
      if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
        en <= reg_req.wdata[CTRL_MUTE_EN_BIT];
        fast <= reg_req.wdata[CTRL_FAST_BIT];
      end
      run <= (|corr) ? run + 1 : 0;
      // Only first-carrier pulses renew the main mute
      quiet <= (acq_pulse && vco_sel[0]) ? 0 : (quiet < MUTE_HOLD_CYC + 9 ? quiet + 1 : quiet);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sel_onehot_a: assert property ($onehot(vco_sel))
    else $error("counter select not one-hot");
  sel_hold_a: assert property ($changed(vco_sel) |=> $stable(vco_sel) [*8])
    else $error("counter select changed early");
  corr_sel_a: assert property ((corr & ~vco_sel) == 3'h0 && (corr_up & corr_dn) == 3'h0)
    else $error("correction on wrong oscillator");
  corr_width_a: assert property ($fell(|corr) |-> run == PW)
    else $error("correction pulse length wrong");
  acq_corr_a: assert property (acq_pulse |=> |corr[1:0])
    else $error("pulse without carrier correction");
  acq_carrier_a: assert property (acq_pulse |-> !vco_sel[2])
    else $error("pulse from pilot slot");
  mute_now_a: assert property (acq_pulse && en |=> mute_second && (mute_main || !$past(vco_sel[0])))
    else $error("mute not raised at once");
  mute_both_a: assert property (mute_main |-> mute_second)
    else $error("second channel left on");
  mute_off_a: assert property (!en && !$past(en) |-> !mute_main && !mute_second)
    else $error("mute while disabled");
  mute_hold_a: assert property ($fell(mute_main) && en |-> quiet + 2 >= MUTE_HOLD_CYC)
    else $error("mute released early");
  mute_rel_a: assert property (quiet > MUTE_HOLD_CYC + 2 |-> !mute_main)
    else $error("mute not released");
  ident_drop_a: assert property ($changed(fast) |=> !ident_valid [*8])
    else $error("ident valid across mode change");
  rst_state_a: assert property ($rose(rst_b) |-> mute_main && mute_second && !ident_valid)
    else $error("wrong state after reset");
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  cover property (acq_pulse && en);
  cover property ($fell(mute_main));
  cover property ($rose(corr_dn[2]));
  cover property (vco_sel[2] && vco_tick[2]);
endmodule : fpa_monitor

// File: test/fpa_vco_model.sv
// Purpose: Oscillator model giving a set number of strobes per slot
// Assumes: Strobes already prescaled to the counter input rate
// Notes: Burst starts 100 cycles into each slot, one strobe every 4 cycles
`timescale 1ns/1ps
module fpa_vco_model (
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [2:0] vco_sel, // Counter select
  input wire logic [23:0] tick_n, // Strobes per slot, 8 bits each
  output logic [2:0] vco_tick // Oscillator strobes
);
  logic [2:0] sel_q;
  int unsigned age;
  // Spaced strobe burst after each select change
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 3'h0;
      age <= 0;
      vco_tick <= 3'h0;
    end else begin
      sel_q <= vco_sel;
      age <= (vco_sel != sel_q) ? 0 : age + 1;
      for (int i = 0; i < 3; i++) begin
        vco_tick[i] <= age >= 100 && age % 4 == 0 && (age - 100) / 4 < tick_n[i*8 +: 8];
      end
    end
  end
endmodule : fpa_vco_model

// File: test/fpa_acq_mute_test.sv
// Purpose: Self-checking bench for acquisition help and auto-mute
// Assumes: Pilot preset 6, window 3 to 3 at the default pilot rate
// Notes: Mute hold and ident times shortened by parameter
`timescale 1ns/1ps
module fpa_acq_mute_test;
  import fpa_pkg::*;
  localparam int unsigned HOLD = 14000;
  localparam int PW = PULSE_CYC - 1;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  fpa_req_type reg_req = '0;
  logic [31:0] reg_rdata;
  logic [2:0] vco_tick, vco_sel, corr_up, corr_dn;
  logic acq_pulse, mute_main, mute_second, ident_valid;
  logic [23:0] tick_n = 24'h060000;
  logic [2:0] sel_q = 3'h0;
  int up_n [3];
  int dn_n [3];
  int acq_n, cyc_n;
  int err_count = 0;
  int checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  fpa_acq_mute #(.MUTE_HOLD_CYC(HOLD), .IDENT_NORM_CYC(400), .IDENT_FAST_CYC(100)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .vco_tick(vco_tick), .vco_sel(vco_sel), .corr_up(corr_up), .corr_dn(corr_dn),
    .acq_pulse(acq_pulse), .mute_main(mute_main), .mute_second(mute_second),
    .ident_valid(ident_valid));
  fpa_vco_model vco (.sys_clk(sys_clk), .rst_b(rst_b), .vco_sel(vco_sel),
    .tick_n(tick_n), .vco_tick(vco_tick));
  // Tally correction cycles, pulses and clocks
  always @(posedge sys_clk) begin
    sel_q <= vco_sel;
    acq_n <= acq_n + acq_pulse;
    cyc_n <= cyc_n + 1;
    for (int i = 0; i < 3; i++) begin
      up_n[i] <= up_n[i] + corr_up[i];
      dn_n[i] <= dn_n[i] + corr_dn[i];
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  // Wait for a slot start of one oscillator, ends 1 ns after the edge
  task automatic sync(input int i);
    int k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (!(vco_sel[i] && !sel_q[i]) && k < 14000);
    if (k >= 14000) begin
      chk("slot start", 1'b0, 1'b1);
      close_out();
    end
  endtask : sync
  task automatic waitv(input logic v, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (ident_valid !== v && n < 1000);
    if (n >= 1000) begin
      chk("ident wait", 1'b0, 1'b1);
      close_out();
    end
    @(posedge sys_clk);
  endtask : waitv
  // Measure one full acquisition cycle
  task automatic cycle(input int eu [3], input int ed [3], input int ea);
    int u [3];
    int d [3];
    int a;
    int c;
    sync(0);
    a = acq_n;
    c = cyc_n;
    u = up_n;
    d = dn_n;
    sync(0);
    chk("cycle length", cyc_n - c, ACQ_CYCLE_CYC);
    chk("acquisition pulses", acq_n - a, ea);
    for (int i = 0; i < 3; i++) begin
      chk("up current", up_n[i] - u[i], eu[i]);
      chk("down current", dn_n[i] - d[i], ed[i]);
    end
  endtask : cycle
  initial begin
    logic [31:0] d;
    int n;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("mute main", mute_main, 1'b1);
    chk("counter select", vco_sel, 3'h1);
    @(posedge sys_clk);
    rd(ADDR_CTRL, d);
    chk("control", d, 32'h5);
    wr(ADDR_STATUS, 32'hffffffff);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    rd(ADDR_STATUS, d);
    chk("status", d[2:0], 3'h3);
    $display("test reset done");
    waitv(1'b1, n);
    wr(ADDR_CTRL, 32'h7);
    waitv(1'b0, n);
    waitv(1'b1, n);
    // Cycles from the write edge are n plus the three edges the waits add
    chk("fast settle", n + 3 > 90 && n + 3 <= 100, 1'b1);
    // Host keeps the fast-mode result before going back to normal
    rd(ADDR_STATUS, d);
    chk("stored ident", d[STAT_IDENT_BIT], 1'b1);
    wr(ADDR_CTRL, 32'h5);
    waitv(1'b0, n);
    waitv(1'b1, n);
    chk("normal settle", n + 3 > 390 && n + 3 <= 400, 1'b1);
    $display("test ident done");
    // Carriers absent, pilot too fast
    cycle('{PW, PW, 0}, '{0, 0, PW}, 2);
    chk("mute main", mute_main, 1'b1);
    $display("test out of window done");
    // Pilot inside window, mute disabled
    sync(2);
    @(posedge sys_clk);
    tick_n <= 24'h030000;
    wr(ADDR_CTRL, 32'h4);
    cycle('{PW, PW, 0}, '{0, 0, 0}, 2);
    chk("mute off", {mute_main, mute_second}, 2'h0);
    $display("test mute disabled done");
    // Standard without second carrier
    sync(2);
    @(posedge sys_clk);
    wr(ADDR_CTRL, 32'h9);
    cycle('{PW, 0, 0}, '{0, 0, 0}, 1);
    chk("mute both", {mute_main, mute_second}, 2'h3);
    $display("test first carrier missing done");
    // No valid table entry, mute then releases
    sync(2);
    @(posedge sys_clk);
    wr(ADDR_CTRL, 32'h19);
    cycle('{0, 0, 0}, '{0, 0, 0}, 0);
    repeat (HOLD) @(posedge sys_clk);
    #1;
    chk("mute released", {mute_main, mute_second}, 2'h0);
    $display("test mute release done");
    close_out();
  end
endmodule : fpa_acq_mute_test
bind fpa_acq_mute fpa_monitor #(.MUTE_HOLD_CYC(MUTE_HOLD_CYC)) mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .vco_tick(vco_tick), .vco_sel(vco_sel), .corr_up(corr_up), .corr_dn(corr_dn),
  .acq_pulse(acq_pulse), .mute_main(mute_main), .mute_second(mute_second),
  .ident_valid(ident_valid));
